//--- verilog/scms_pkg.sv
// Purpose: shared constants, types and spread decoding for the clock select block
// Assumes: registers reached over APB with 32-bit words and 12-bit byte addresses
// Notes: deviation unit is 0.125 %; the ramp position is scaled by 256

package scms_pkg;

	// widths of the strap groups, the excursions, the ramp output and the register address
	localparam int MULT_W   = 3;
	localparam int SPREAD_W = 4;
	localparam int RATE_W   = 2;
	localparam int DEV_W    = 5;
	localparam int TRI_W    = 16;
	localparam int ADDR_W   = 12;

	// modulation period: one full triangle every 512 reference edges
	localparam int TRI_PERIOD = 512;
	localparam int TRI_CNT_W  = $clog2(TRI_PERIOD);

	// deviation units per unit ratio (0.125 % steps), times ramp scale 256
	localparam int DEV_UNITS_PER_ONE = 800;
	localparam int RAMP_SCALE        = 256;
	localparam int DEV_DEN           = DEV_UNITS_PER_ONE * RAMP_SCALE;

	// strap code for spread off, and the settle count before rate capture
	localparam logic [SPREAD_W-1:0] SPREAD_OFF = 4'hf;
	localparam logic [1:0]          CAPTURE_WAIT = 2'h3;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_SPREAD   = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_BASE_INC = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_INC_NOW  = 12'h010;

	// status field positions
	localparam int ST_LATCHED = 0;
	localparam int ST_RATE    = 1;
	localparam int ST_MULT    = 3;
	localparam int ST_SPREAD  = 6;
	localparam int ST_OE      = 10;
	// spread field positions
	localparam int SP_UP   = 0;
	localparam int SP_DN   = 8;
	localparam int SP_KIND = 16;
	// control field positions
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_SPREAD_EN = 1;

	// reset values
	localparam logic [31:0] BASE_INC_RST = 32'h1000_0000;
	localparam logic [1:0]  CTRL_RST     = 2'h3;

	typedef enum logic [3:0] {
		SCMS_OFF    = 4'h1,
		SCMS_CENTER = 4'h2,
		SCMS_DOWN   = 4'h4,
		SCMS_ASYM   = 4'h8
	} scms_kind_e;

	typedef enum logic [1:0] {
		SCMS_CAP_WAIT = 2'h1,
		SCMS_CAP_RUN  = 2'h2
	} scms_cap_e;

	typedef struct packed {
		logic [MULT_W-1:0]   mult;
		logic [SPREAD_W-1:0] spread;
		logic [RATE_W-1:0]   rate;
		logic                oe;
		logic                refc;
	} scms_sel_s;

	typedef struct packed {
		scms_kind_e       kind;
		logic [DEV_W-1:0] up;
		logic [DEV_W-1:0] dn;
	} scms_spread_s;

	// strap decode: total excursion 2*(code+1) units, upper part cut by a knee of 4 per
	// zero rate weight; knee zero gives center, knee at or above half gives pure down
	function automatic scms_spread_s scms_decode(input logic [RATE_W-1:0] rate,
		input logic [SPREAD_W-1:0] sc);
		scms_spread_s     r;
		logic [DEV_W-1:0] half;
		logic [DEV_W-1:0] knee;
		logic [DEV_W-1:0] tot;
		half   = {1'b0, sc} + 5'h01;
		knee   = {1'b0, ~rate, 2'b00};
		tot    = {half[DEV_W-2:0], 1'b0};
		r.kind = SCMS_OFF;
		r.up   = '0;
		r.dn   = '0;
		if (sc != SPREAD_OFF)
		begin
			r.up = (half > knee) ? half - knee : '0;
			r.dn = tot - r.up;
			if (r.up == r.dn)
				r.kind = SCMS_CENTER;
			else if (r.up == '0)
				r.kind = SCMS_DOWN;
			else
				r.kind = SCMS_ASYM;
		end
		return r;
	endfunction

endpackage

//--- verilog/scms_tri.sv
// Purpose: triangle modulation profile stepped by reference clock edges
// Assumes: step is a one-cycle pulse per reference rising edge
// Notes: output in units of 0.125 % / 256, from -dn up to near +up and back
`timescale 1ns/1ns

module scms_tri
	import scms_pkg::*;
(
	input  wire logic                    ref_clk, // system clock
	input  wire logic                    resetn,  // async reset, active low
	input  wire logic                    step,    // reference edge pulse
	input  wire logic [DEV_W-1:0]        up,      // upper excursion
	input  wire logic [DEV_W-1:0]        dn,      // lower excursion
	output logic signed [TRI_W-1:0]      dev      // current deviation
);

	typedef struct packed {
		logic [TRI_CNT_W-1:0] cnt;
		logic [TRI_W-1:0]     dev;
	} scms_tri_s;

	scms_tri_s q;
	scms_tri_s d;
	logic [7:0]  pos;
	logic [DEV_W:0] tot;
	logic [12:0] prod;
	logic [12:0] base;

	// first half of the period ramps up, second half ramps down
	always_comb
	begin
		d     = q;
		pos   = q.cnt[TRI_CNT_W-1] ? ~q.cnt[7:0] : q.cnt[7:0];
		tot   = {1'b0, up} + {1'b0, dn};
		prod  = 13'(pos * tot);
		base  = {dn, 8'h00};
		d.dev = TRI_W'($signed({3'b000, prod}) - $signed({3'b000, base}));
		if (step)
			d.cnt = q.cnt + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign dev = $signed(q.dev);

endmodule

//--- verilog/scms_nco.sv
// Purpose: phase accumulator that turns a frequency word into a clock
// Assumes: inc is a fraction of the system clock rate, full scale 2^32
// Notes: output is the accumulator top bit, so it carries system clock jitter
`timescale 1ns/1ns

module scms_nco
	import scms_pkg::*;
(
	input  wire logic        ref_clk, // system clock
	input  wire logic        resetn,  // async reset, active low
	input  wire logic        run,     // advance the phase
	input  wire logic [31:0] inc,     // phase step per cycle
	output logic             clk_out  // synthesized clock
);

	typedef struct packed {
		logic [31:0] acc;
	} scms_nco_s;

	scms_nco_s q;
	scms_nco_s d;

	// hold phase while stopped so restart does not glitch
	always_comb
	begin
		d = q;
		if (run)
			d.acc = q.acc + inc;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign clk_out = q.acc[31];

endmodule

//--- verilog/scms_top.sv
// Purpose: strap decode, power-up rate capture, pin reuse and clock synthesis
// Assumes: all strap pins and the reference clock are asynchronous to ref_clk
// Notes: the synthesized clock is a digital model of the multiplied, spread output
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] The three multiplier strap bits form a binary code n and the output runs at (n+1) times the reference.
// [RULE2] The output is first multiplied by the chosen factor 1X to 8X and then the chosen spread is applied.
// [RULE3] The two rate bits are caught once at power-up and held; later pin levels are ignored.
// [RULE4] After the first rate bit is caught its pin becomes the crystal drive.
// [RULE5] After the second rate bit is caught its pin drives a buffered copy of the reference clock.
// [RULE6] A low output enable puts all clock outputs in high impedance, a high one drives them; the code leaves crystal_drive driven regardless.
// [RULE7] Any selection input left open reads as one, so an open device selects all ones.
// [RULE8] Spread code all ones turns modulation off whatever the rate bits hold.
// [RULE9] With both rate bits one the spread is centred, plus or minus 0.125 % per step up to 1.875 %.
// [RULE10] Some rate and code pairs give pure down spread of 1, 2 or 3 %, most others asymmetric spread.
// [RULE11] The board holds each selection static and has the rate levels valid at power-up.
// [RULE12] Rate capture happens once after reset release; the other selections are sampled continuously.
module scms_top
	import scms_pkg::*;
(
	input  wire logic              ref_clk,                // system clock, 125 MHz
	input  wire logic              resetn,                 // power-on reset, active low
	// register bus, zero wait states
	input  wire logic [ADDR_W-1:0] paddr,                  // apb address
	input  wire logic              psel,                   // apb select
	input  wire logic              penable,                // apb access phase
	input  wire logic              pwrite,                 // apb write
	input  wire logic [31:0]       pwdata,                 // apb write data
	input  wire logic [3:0]        pstrb,                  // apb byte strobes
	output logic [31:0]            prdata,                 // apb read data
	output logic                   pready,                 // apb ready
	output logic                   pslverr,                // apb error

	// strap pins, static levels from the board
	input  wire logic              mult_sel_bit0,          // multiplier strap bit 0
	input  wire logic              mult_sel_bit1,          // multiplier strap bit 1
	input  wire logic              mult_sel_bit2,          // multiplier strap bit 2
	input  wire logic              spread_sel_bit0,        // spread strap bit 0
	input  wire logic              spread_sel_bit1,        // spread strap bit 1
	input  wire logic              spread_sel_bit2,        // spread strap bit 2
	input  wire logic              spread_sel_bit3,        // spread strap bit 3

	// enable and reference, both asynchronous
	input  wire logic              output_enable,          // clock output enable
	input  wire logic              reference_clock_in,     // reference clock pin

	// shared pins: strap input first, then the output side
	input  wire logic              rate_sel_bit0,          // shared pin, input side
	output logic                   crystal_drive,          // shared pin, output side
	output logic                   crystal_drive_oe,       // shared pin driven
	input  wire logic              rate_sel_bit1,          // shared pin, input side
	output logic                   ref_buf_out,            // shared pin, buffered ref
	output logic                   ref_buf_oe,             // shared pin driven

	// synthesized clock
	output logic                   modulated_clock_out,    // synthesized clock
	output logic                   modulated_clock_out_oe  // synthesized clock driven
);

	// open pins are pulled high, so the synchronisers start from all ones except the reference level, which starts low
	localparam scms_sel_s SEL_RST = '{
		mult:   '1,
		spread: '1,
		rate:   '1,
		oe:     1'b1,
		refc:   1'b0
	};

	typedef struct packed {
		scms_sel_s        sel_m;    // first synchroniser stage
		scms_sel_s        sel;      // second synchroniser stage
		logic             ref_p;    // previous reference level
		scms_cap_e        cap;      // capture state
		logic [1:0]       wait_cnt; // settle count before capture
		logic [RATE_W-1:0] rate_lat; // captured rate bits
		logic [31:0]      base_inc; // phase step of one reference
		logic [1:0]       ctrl;     // run and spread enable
		logic [31:0]      inc;      // current phase step
		logic [31:0]      rdata;    // apb read data
		logic             err;      // apb error
		logic             xtal;     // crystal drive level
		logic             refb;     // buffered reference level
	} scms_top_s;

	localparam scms_top_s TOP_RST = '{
		sel_m:    SEL_RST,
		sel:      SEL_RST,
		ref_p:    1'b0,
		cap:      SCMS_CAP_WAIT,
		wait_cnt: 2'h0,
		rate_lat: 2'h3,
		base_inc: BASE_INC_RST,
		ctrl:     CTRL_RST,
		inc:      32'h0000_0000,
		rdata:    32'h0000_0000,
		err:      1'b0,
		xtal:     1'b0,
		refb:     1'b0
	};

	// state and its next value
	scms_top_s          q;
	scms_top_s          d;

	// raw pin bundle, before synchronisation
	scms_sel_s          pins;

	// spread setting from straps, and after the software override
	scms_spread_s       strap_cfg;
	scms_spread_s       mod_cfg;

	// capture and bus decode
	logic               ref_rise;
	logic               latched;
	logic               wr_en;
	logic               rd_setup;

	// frequency word path: multiply first, then add the spread offset
	logic [3:0]         factor;
	logic [35:0]        mult_prod;
	logic [31:0]        mult_inc;
	logic signed [TRI_W-1:0] dev;
	logic signed [48:0] dev_prod;
	logic signed [48:0] dev_off;

	// synthesized clock before the pin
	logic               nco_clk;

	// byte-lane merge for writable words
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = wdata[8*i +: 8];
		end
		return r;
	endfunction

	// gather loose pins; the shared rate pins are read only while undriven
	always_comb
	begin
		pins.mult   = {mult_sel_bit2, mult_sel_bit1, mult_sel_bit0};
		pins.spread = {spread_sel_bit3, spread_sel_bit2, spread_sel_bit1, spread_sel_bit0};
		pins.rate   = {rate_sel_bit1, rate_sel_bit0};
		pins.oe     = output_enable;
		pins.refc   = reference_clock_in;
	end

	assign ref_rise = q.sel.refc & ~q.ref_p;
	assign latched  = (q.cap == SCMS_CAP_RUN);
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	// [RULE8] spread off code
	// [RULE9] center spread steps
	// [RULE10] down and asymmetric
	assign strap_cfg = scms_decode(q.rate_lat, q.sel.spread);

	// software can force spread off without touching the straps
	always_comb
	begin
		mod_cfg = strap_cfg;
		if (!q.ctrl[CTRL_SPREAD_EN])
		begin
			mod_cfg.kind = SCMS_OFF;
			mod_cfg.up   = '0;
			mod_cfg.dn   = '0;
		end
	end

	// [RULE1] binary multiplier code
	assign factor    = {1'b0, q.sel.mult} + 4'h1;
	assign mult_prod = q.base_inc * factor;
	assign mult_inc  = mult_prod[31:0];

	// [RULE2] spread applied after multiply
	assign dev_prod = $signed({17'h0_0000, mult_inc}) * dev;
	assign dev_off  = dev_prod / $signed(49'(DEV_DEN));

	// state update
	always_comb
	begin
		d = q;

		// two stages on every pin before anything looks at it
		d.sel_m = pins;
		d.sel   = q.sel_m;
		d.ref_p = q.sel.refc;

		// [RULE3] one-time capture
		// [RULE12] capture after release
		case (q.cap)
			// wait for the synchronisers to fill before trusting the pins
			SCMS_CAP_WAIT:
			begin
				if (q.wait_cnt == CAPTURE_WAIT)
				begin
					d.rate_lat = q.sel.rate;
					d.cap      = SCMS_CAP_RUN;
				end
				else
				begin
					d.wait_cnt = q.wait_cnt + 2'h1;
				end
			end

			// latched for good; the rate pins are outputs from here on
			SCMS_CAP_RUN:
			begin
				d.cap = SCMS_CAP_RUN;
			end

			// an upset code restarts the capture rather than lock up
			default:
			begin
				d.cap = SCMS_CAP_WAIT;
			end
		endcase

		// [RULE4] crystal drive reuse
		d.xtal = ~q.sel.refc;
		// [RULE5] buffered reference copy
		d.refb = q.sel.refc;

		// pipeline the frequency word to keep the divider off the output path
		d.inc = mult_inc + dev_off[31:0];

		// register writes land in the access cycle
		if (wr_en)
		begin
			if (paddr == ADDR_BASE_INC)
				d.base_inc = strb_merge(q.base_inc, pwdata, pstrb);
			else if (paddr == ADDR_CTRL)
			begin
				// only the low byte carries control bits
				if (pstrb[0])
					d.ctrl = pwdata[1:0];
			end
			// other offsets are read only or unmapped: writes are dropped
		end

		// read data and error are set up one cycle ahead of the access phase
		if (rd_setup)
		begin
			d.rdata = 32'h0000_0000;
			d.err   = 1'b0;

			// capture flag, latched rate, live straps and enable
			if (paddr == ADDR_STATUS)
			begin
				d.rdata[ST_LATCHED]             = latched;
				d.rdata[ST_RATE +: RATE_W]      = q.rate_lat;
				d.rdata[ST_MULT +: MULT_W]      = q.sel.mult;
				d.rdata[ST_SPREAD +: SPREAD_W]  = q.sel.spread;
				d.rdata[ST_OE]                  = q.sel.oe;
			end

			// excursions as applied, after the software override
			else if (paddr == ADDR_SPREAD)
			begin
				d.rdata[SP_UP +: DEV_W] = mod_cfg.up;
				d.rdata[SP_DN +: DEV_W] = mod_cfg.dn;
				d.rdata[SP_KIND +: 4]   = mod_cfg.kind;
			end
			else if (paddr == ADDR_BASE_INC)
			begin
				d.rdata = q.base_inc;
			end
			else if (paddr == ADDR_CTRL)
			begin
				d.rdata[1:0] = q.ctrl;
			end

			// live step, moves with the modulation
			else if (paddr == ADDR_INC_NOW)
			begin
				d.rdata = q.inc;
			end

			// unmapped: flag an error, read data stays zero
			else
			begin
				d.err = 1'b1;
			end
		end
	end

	// [RULE7] open pins read high
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			q <= TOP_RST;
		else
			q <= d;
	end

	// modulation profile, stepped once per reference edge
	scms_tri u_tri (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.step    (ref_rise),
		.up      (mod_cfg.up),
		.dn      (mod_cfg.dn),
		.dev     (dev)
	);

	// the synthesized clock only starts once the rate bits are fixed
	scms_nco u_nco (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.run     (q.ctrl[CTRL_RUN] & latched),
		.inc     (q.inc),
		.clk_out (nco_clk)
	);

	// apb answers with zero wait states; read data was loaded in the setup cycle,
	// so the output path carries no decode logic

	assign pready  = psel & penable;
	assign prdata  = q.rdata;
	assign pslverr = q.err & psel & penable;

	// [RULE4] pin turns to output
	// the oscillator keeps running with outputs off, so this pin ignores enable

	assign crystal_drive    = q.xtal;
	assign crystal_drive_oe = latched;

	// [RULE5] reference out after capture
	// [RULE6] enable gates clock outputs
	assign ref_buf_out            = q.refb;
	assign ref_buf_oe             = latched & q.sel.oe;
	assign modulated_clock_out    = nco_clk;
	assign modulated_clock_out_oe = q.sel.oe;

endmodule

//--- testbench/scms_board.sv
// Purpose: board strapping and reference source around the clock select block
// Assumes: a strap bit tied low reads 0, an open one reads 1 through its pull-up
// Notes: the shared pins show the device's drive once it turns them round
`timescale 1ns/1ns

module scms_board
	import scms_pkg::*;
(
	input  wire logic [MULT_W-1:0]   m_gnd,      // multiplier straps tied low
	input  wire logic [SPREAD_W-1:0] s_gnd,      // spread straps tied low
	input  wire logic [RATE_W-1:0]   r_gnd,      // rate pull-down resistors fitted
	input  wire logic                oe_gnd,     // output enable tied low
	input  wire logic                xd,         // crystal drive from device
	input  wire logic                xd_oe,      // crystal drive enable
	input  wire logic                rb,         // buffered reference from device
	input  wire logic                rb_oe,      // buffered reference enable
	output wire logic [MULT_W-1:0]   m_pin,      // multiplier pins
	output wire logic [SPREAD_W-1:0] s_pin,      // spread pins
	output wire logic [RATE_W-1:0]   r_pin,      // shared pins
	output wire logic                oe_pin,     // output enable pin
	output logic                     rc_pin      // reference clock pin
);
	assign m_pin = ~m_gnd;
	assign s_pin = ~s_gnd;
	assign oe_pin = ~oe_gnd;
	// the device drive wins over the strap resistor once enabled
	assign r_pin[0] = xd_oe ? xd : ~r_gnd[0];
	assign r_pin[1] = rb_oe ? rb : ~r_gnd[1];
	// reference near 24 MHz, off the system clock grid
	initial
	begin
		rc_pin = 1'b0;
		#3;
		forever #21 rc_pin = ~rc_pin;
	end
endmodule

//--- testbench/scms_sva.sv
// Purpose: port-level checks of the clock select block
// Assumes: one clock domain, resetn asynchronous and active low
// Notes: edges since reset release are counted here, saturating at 15
`timescale 1ns/1ns

module scms_sva
	import scms_pkg::*;
(
	input wire logic              ref_clk,                // system clock
	input wire logic              resetn,                 // reset, active low
	input wire logic [ADDR_W-1:0] paddr,                  // apb address
	input wire logic              psel,                   // apb select
	input wire logic              penable,                // apb access
	input wire logic [31:0]       prdata,                 // apb read data
	input wire logic              pready,                 // apb ready
	input wire logic              pslverr,                // apb error
	input wire logic              output_enable,          // clock output enable
	input wire logic              reference_clock_in,     // reference pin
	input wire logic              crystal_drive,          // shared pin output
	input wire logic              crystal_drive_oe,       // shared pin driven
	input wire logic              ref_buf_out,            // buffered reference
	input wire logic              ref_buf_oe,             // buffered reference driven
	input wire logic              modulated_clock_out_oe  // synthesized clock driven
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	// saturating count; capture checks only need the first dozen edges
	always_comb cnt_d = (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_d;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
	a_apb_err: assert property (psel && penable |-> pslverr == (paddr > ADDR_INC_NOW))
		else $error("error flag wrong");
	a_rdata_hold: assert property (psel && penable |=> $stable(prdata)) else $error("rdata moved");
	a_pin_input: assert property (cnt_q < 4'h3 |-> !crystal_drive_oe && !ref_buf_oe)
		else $error("shared pin driven early");
	a_pin_turned: assert property (cnt_q == 4'ha |-> crystal_drive_oe)
		else $error("crystal drive not on");
	a_pin_sticky: assert property (crystal_drive_oe |=> crystal_drive_oe)
		else $error("crystal drive dropped");
	a_ref_pair: assert property (ref_buf_oe |-> crystal_drive != ref_buf_out)
		else $error("crystal and buffer not complementary");
	a_ref_follow: assert property ($rose(ref_buf_out) |-> $past(reference_clock_in, 2)
		|| $past(reference_clock_in, 3) || $past(reference_clock_in, 4)) else $error("ref lag");
	a_oe_tristate: assert property (!output_enable [*4] |->
		!modulated_clock_out_oe && !ref_buf_oe) else $error("outputs not released");
	a_oe_drive: assert property ((output_enable && cnt_q > 4'ha) [*4] |->
		modulated_clock_out_oe && ref_buf_oe) else $error("outputs not driven");
	c_unmapped: cover property (psel && penable && pslverr);
	c_tristate: cover property (!modulated_clock_out_oe);
	c_turned: cover property (ref_buf_oe && crystal_drive_oe);
endmodule

bind scms_top scms_sva sva_i (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.output_enable(output_enable), .reference_clock_in(reference_clock_in),
	.crystal_drive(crystal_drive), .crystal_drive_oe(crystal_drive_oe),
	.ref_buf_out(ref_buf_out), .ref_buf_oe(ref_buf_oe),
	.modulated_clock_out_oe(modulated_clock_out_oe));

//--- testbench/spread_clock_mult_select_tb_top.sv
// Purpose: self-checking bench for the clock select block
// Assumes: straps come through the board model, registers through apb tasks
// Notes: rate capture needs a fresh power-up, so each rate code gets its own
`timescale 1ns/1ns

module spread_clock_mult_select_tb_top;
	import scms_pkg::*;
	logic                ref_clk = 1'b0;
	logic                resetn  = 1'b0;
	logic [ADDR_W-1:0]   paddr   = '0;
	logic                psel    = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite  = 1'b0;
	logic [31:0]         pwdata  = '0;
	logic [MULT_W-1:0]   m_gnd   = '0;
	logic [SPREAD_W-1:0] s_gnd   = '0;
	logic [RATE_W-1:0]   r_gnd   = '0;
	logic                oe_gnd  = 1'b0;
	logic [31:0]         prdata, q, b;
	logic                pready, pslverr, xd, xd_oe, rb, rb_oe, mc, mc_oe, e, p0, p1, p2;
	wire  [MULT_W-1:0]   m_pin;
	wire  [SPREAD_W-1:0] s_pin;
	wire  [RATE_W-1:0]   r_pin;
	wire                 oe_pin, rc_pin;
	int                  num_errors = 0;
	int                  check_count = 0;
	int                  cyc = 0;
	int                  n0, n1, n2, e2;
	logic [3:0]          c;
	// literal corners: [29:28] rate, [23:20] code, [19:0] expected spread word
	logic [31:0]         corner [7] = '{32'h2034_0800, 32'h1074_1000, 32'h00b4_1800,
		32'h2048_0901, 32'h1088_1101, 32'h30e2_0f0f, 32'h00f1_0000};

	scms_top uut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mult_sel_bit0(m_pin[0]), .mult_sel_bit1(m_pin[1]),
		.mult_sel_bit2(m_pin[2]), .spread_sel_bit0(s_pin[0]), .spread_sel_bit1(s_pin[1]),
		.spread_sel_bit2(s_pin[2]), .spread_sel_bit3(s_pin[3]), .output_enable(oe_pin),
		.reference_clock_in(rc_pin), .rate_sel_bit0(r_pin[0]), .crystal_drive(xd),
		.crystal_drive_oe(xd_oe), .rate_sel_bit1(r_pin[1]), .ref_buf_out(rb),
		.ref_buf_oe(rb_oe), .modulated_clock_out(mc), .modulated_clock_out_oe(mc_oe));
	scms_board board (.m_gnd(m_gnd), .s_gnd(s_gnd), .r_gnd(r_gnd), .oe_gnd(oe_gnd), .xd(xd),
		.xd_oe(xd_oe), .rb(rb), .rb_oe(rb_oe), .m_pin(m_pin), .s_pin(s_pin), .r_pin(r_pin),
		.oe_pin(oe_pin), .rc_pin(rc_pin));

	always #4 ref_clk = ~ref_clk;

	task automatic conclude();
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard: the whole run needs well under two thousand cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; the request stands until ready is seen high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n == 20)
			num_errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// expected excursions: total 2*(code+1) units, top part shrinks by 4 per zero rate weight
	function automatic logic [31:0] exp_spread(input logic [1:0] r, input logic [3:0] sc);
		logic [4:0] h, k, u, d;
		logic [3:0] kd;
		h = 5'(sc) + 5'h01;
		k = 5'(3 - r) << 2;
		u = (h > k) ? h - k : 5'h00;
		d = (h << 1) - u;
		kd = (u == d) ? 4'h2 : (u == 5'h00) ? 4'h4 : 4'h8;
		if (sc == SPREAD_OFF)
			return 32'h0001_0000;
		return {12'h000, kd, 3'b000, d, 3'b000, u};
	endfunction

	task automatic status(input logic [1:0] r);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		check("status", q & 32'h0000_07ff, 32'({~oe_gnd, ~s_gnd, ~m_gnd, r, 1'b1}));
	endtask

	initial
	begin
		q = $urandom(32'h5549);
		for (int r = 3; r >= 0; r--)
		begin
			// power-up with the rate resistors of this pass fitted
			resetn <= 1'b0;
			r_gnd <= ~2'(r);
			repeat (5) @(posedge ref_clk);
			resetn <= 1'b1;
			repeat (12) @(posedge ref_clk);
			status(2'(r));
			@(negedge ref_clk);
			check("shared pins", 32'({xd_oe, rb_oe}), 32'h0000_0003);
			// straps move at random; rate resistors change too and must not count
			for (int i = 0; i < 7; i++)
			begin
				@(posedge ref_clk);
				c = (corner[i][29:28] == 2'(r)) ? corner[i][23:20] : 4'($urandom);
				m_gnd <= 3'($urandom);
				s_gnd <= ~c;
				r_gnd <= 2'($urandom);
				repeat (6) @(posedge ref_clk);
				apb(1'b0, ADDR_SPREAD, 32'h0000_0000);
				check("spread", q & 32'h000f_1f1f, (corner[i][29:28] == 2'(r) && corner[i][23:20]
					== c) ? 32'(corner[i][19:0]) : exp_spread(2'(r), c));
			end
			status(2'(r));
			if (r == 3)
			begin
				apb(1'b0, ADDR_BASE_INC, 32'h0000_0000);
				check("base reset", q, BASE_INC_RST);
				apb(1'b0, ADDR_CTRL, 32'h0000_0000);
				check("ctrl reset", q & 32'h0000_0003, 32'(CTRL_RST));
				apb(1'b0, 12'h100, 32'h0000_0000);
				check("unmapped", {q[30:0], e}, 32'h0000_0001);
				// spread off so the step is the bare product
				b = ($urandom & 32'h0fff_ffff) | 32'h0100_0000;
				apb(1'b1, ADDR_CTRL, 32'h0000_0001);
				apb(1'b1, ADDR_BASE_INC, b);
				for (int m = 0; m < 8; m++)
				begin
					m_gnd <= ~3'(m);
					repeat (6) @(posedge ref_clk);
					apb(1'b0, ADDR_INC_NOW, 32'h0000_0000);
					check("step", q, b * 32'(m + 1));
				end
				apb(1'b1, ADDR_CTRL, 32'h0000_0003);
				// crystal drive keeps running while the outputs float
				oe_gnd <= 1'b1;
				repeat (6) @(negedge ref_clk);
				check("oe low", 32'({mc_oe, rb_oe, xd_oe}), 32'h0000_0001);
				@(posedge ref_clk);
				oe_gnd <= 1'b0;
				n0 = 0;
				n1 = 0;
				n2 = 0;
				p0 = 1'b1;
				p1 = 1'b1;
				p2 = 1'b1;
				// buffered reference must keep pace with the reference pin
				repeat (840)
				begin
					@(negedge ref_clk);
					n0 += int'(rc_pin && !p0);
					n1 += int'(rb && !p1);
					n2 += int'(mc && !p2);
					p0 = rc_pin;
					p1 = rb;
					p2 = mc;
				end
				check("ref rate", 32'(n1 > 100 && (n0 - n1) * (n0 - n1) <= 1), 32'h1);
				// x8 output: edges over 6720 ns, spread stays well inside 5 %
				e2 = int'((64'(b) * 64'd6720) >> 32);
				check("clock out", 32'(n2 - e2 <= e2 / 20 + 2 && e2 - n2 <= e2 / 20 + 2), 32'h1);
			end
		end
		conclude();
	end
endmodule
